// file: hdl/stdtm_top.sv
// Standard timer module: 16-bit up-counter, comparators A and P, APB registers
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps

module stdtm_top (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Internal clock strobes, one system cycle wide
	input wire logic high_clock_tick,
	input wire logic sub_clock_tick,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Timer pin and status
	output logic timer_output_pin,
	output logic compare_a_flag,
	output logic compare_p_flag
);

	// ==========================================================
	// Address decode and read mux
	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = (a == stdtm_pkg::ADDR_RUN_CLOCK) || (a == stdtm_pkg::ADDR_MODE_OUT) ||
			(a == stdtm_pkg::ADDR_CNT_LOW) || (a == stdtm_pkg::ADDR_CNT_HIGH) ||
			(a == stdtm_pkg::ADDR_CMPA_LOW) || (a == stdtm_pkg::ADDR_CMPA_HIGH) ||
			(a == stdtm_pkg::ADDR_PERIOD) || (a == stdtm_pkg::ADDR_FLAGS);
	endfunction

	function automatic logic [7:0] read_byte(input logic [7:0] a, input stdtm_pkg::stdtm_state_t st);
		case (a)
			stdtm_pkg::ADDR_RUN_CLOCK: read_byte = {st.run_ctrl[7:3], 3'h0};
			stdtm_pkg::ADDR_MODE_OUT: read_byte = st.mode_ctrl;
			stdtm_pkg::ADDR_CNT_LOW: read_byte = st.cnt[7:0];
			stdtm_pkg::ADDR_CNT_HIGH: read_byte = st.cnt[15:8];
			stdtm_pkg::ADDR_CMPA_LOW: read_byte = st.cmpa[7:0];
			stdtm_pkg::ADDR_CMPA_HIGH: read_byte = st.cmpa[15:8];
			stdtm_pkg::ADDR_PERIOD: read_byte = st.cmpp;
			stdtm_pkg::ADDR_FLAGS: read_byte = {6'h00, st.flag_p, st.flag_a};
			default: read_byte = 8'h00;
		endcase
	endfunction

	stdtm_pkg::stdtm_state_t s_reg;
	stdtm_pkg::stdtm_state_t s_next;

	// ==========================================================
	// Decoded control fields
	logic run;
	logic pause;
	logic [2:0] clk_sel;
	logic [1:0] mode;
	logic [1:0] pin_fn;
	logic init_lvl;
	logic pol;
	logic swap;
	logic clr_src;

	assign run = s_reg.run_ctrl[stdtm_pkg::RUN_BIT];
	assign pause = s_reg.run_ctrl[stdtm_pkg::PAUSE_BIT];
	assign clk_sel = s_reg.run_ctrl[stdtm_pkg::CLK_SEL_LSB +: 3];
	assign mode = s_reg.mode_ctrl[stdtm_pkg::MODE_LSB +: 2];
	assign pin_fn = s_reg.mode_ctrl[stdtm_pkg::PIN_FN_LSB +: 2];
	assign init_lvl = s_reg.mode_ctrl[stdtm_pkg::INIT_LVL_BIT];
	assign pol = s_reg.mode_ctrl[stdtm_pkg::POL_BIT];
	assign swap = s_reg.mode_ctrl[stdtm_pkg::SWAP_BIT];
	assign clr_src = s_reg.mode_ctrl[stdtm_pkg::CLR_SRC_BIT];

	// ==========================================================
	// Next state
	always_comb begin
		logic access;
		logic wr;
		logic run_rise;
		logic tick;
		logic [15:0] inc;
		logic ovf;
		logic a_hit;
		logic p_hit;
		logic clear;
		logic set_a;
		logic set_p;
		logic clr_a;
		logic clr_p;
		logic [16:0] duty;
		logic pwm_on;
		logic drive;
		access = 1'b0;
		wr = 1'b0;
		run_rise = 1'b0;
		tick = 1'b0;
		inc = 16'h0000;
		ovf = 1'b0;
		a_hit = 1'b0;
		p_hit = 1'b0;
		clear = 1'b0;
		set_a = 1'b0;
		set_p = 1'b0;
		clr_a = 1'b0;
		clr_p = 1'b0;
		duty = 17'h00000;
		pwm_on = 1'b0;
		drive = 1'b0;
		s_next = s_reg;
		s_next.run_prev = run;

		// Bus answer: pready rises in the second access cycle
		access = psel && penable;
		s_next.pready = access && !s_reg.pready;
		s_next.pslverr = 1'b0;
		if (access && !s_reg.pready) begin
			s_next.pslverr = !addr_hit(paddr);
			s_next.prdata = {24'h000000, read_byte(paddr, s_reg)};
		end
		wr = access && s_reg.pready && pwrite && addr_hit(paddr);

		// Prescalers run from internal sources only
		s_next.sys_div = s_reg.sys_div + 2'h1;
		if (high_clock_tick) begin
			s_next.hi_div = s_reg.hi_div + 6'h01;
		end
		case (clk_sel)
			stdtm_pkg::CKS_SYS_DIV4: tick = (s_reg.sys_div == stdtm_pkg::SYS_DIV4_LAST);
			stdtm_pkg::CKS_SYS: tick = 1'b1;
			stdtm_pkg::CKS_HI_DIV16: tick = high_clock_tick && (s_reg.hi_div[3:0] == stdtm_pkg::HI_DIV16_LAST[3:0]);
			stdtm_pkg::CKS_HI_DIV64: tick = high_clock_tick && (s_reg.hi_div == stdtm_pkg::HI_DIV64_LAST);
			stdtm_pkg::CKS_SUB_A, stdtm_pkg::CKS_SUB_B: tick = sub_clock_tick;
			default: tick = 1'b0;
		endcase

		// Counter and comparators
		run_rise = run && !s_reg.run_prev;
		inc = s_reg.cnt + 16'h0001;
		if (run && !pause && !run_rise && tick) begin
			ovf = (s_reg.cnt == 16'hffff);
			a_hit = (s_reg.cmpa != 16'h0000) && (inc == s_reg.cmpa);
			p_hit = (s_reg.cmpp == 8'h00) ? ovf : (inc == {s_reg.cmpp, 8'h00});
			if (mode == stdtm_pkg::MODE_PWM) begin
				set_a = a_hit;
				set_p = p_hit;
				if (pin_fn == stdtm_pkg::PFN_PULSE) begin
					clear = a_hit;
				end else begin
					clear = swap ? ((s_reg.cmpa == 16'h0000) ? ovf : a_hit) : p_hit;
				end
			end else if (clr_src) begin
				set_a = a_hit;
				clear = a_hit;
			end else begin
				set_a = a_hit;
				set_p = p_hit;
				clear = p_hit;
			end
			s_next.cnt = clear ? 16'h0000 : inc;
		end
		if (run_rise) begin
			s_next.cnt = 16'h0000;
		end

		// Pin level before polarity
		if (run_rise && (mode != stdtm_pkg::MODE_TIMER)) begin
			s_next.lvl = init_lvl;
		end else if ((mode == stdtm_pkg::MODE_COMPARE) && set_a) begin
			case (pin_fn)
				stdtm_pkg::PFN_LOW: s_next.lvl = 1'b0;
				stdtm_pkg::PFN_HIGH: s_next.lvl = 1'b1;
				stdtm_pkg::PFN_TOGGLE: s_next.lvl = !s_reg.lvl;
				default: s_next.lvl = s_reg.lvl;
			endcase
		end else if ((mode == stdtm_pkg::MODE_PWM) && (pin_fn == stdtm_pkg::PFN_PULSE) && a_hit) begin
			s_next.lvl = !init_lvl;
			s_next.run_ctrl[stdtm_pkg::RUN_BIT] = 1'b0;
		end

		// PWM duty compare on the new count
		duty = swap ? ((s_reg.cmpp == 8'h00) ? 17'h10000 : {1'b0, s_reg.cmpp, 8'h00}) :
			{1'b0, s_reg.cmpa};
		pwm_on = ({1'b0, s_next.cnt} < duty);
		case (pin_fn)
			stdtm_pkg::PFN_INACTIVE: drive = !init_lvl;
			stdtm_pkg::PFN_ACTIVE: drive = init_lvl;
			stdtm_pkg::PFN_PWM: drive = pwm_on ? init_lvl : !init_lvl;
			default: drive = s_next.lvl;
		endcase
		case (mode)
			stdtm_pkg::MODE_PWM: s_next.pin = drive ^ pol;
			stdtm_pkg::MODE_COMPARE: s_next.pin = s_next.lvl ^ pol;
			default: s_next.pin = s_reg.pin;
		endcase

		// Register writes
		if (wr) begin
			case (paddr)
				stdtm_pkg::ADDR_RUN_CLOCK: s_next.run_ctrl = {pwdata[7:3], 3'h0};
				stdtm_pkg::ADDR_MODE_OUT: s_next.mode_ctrl = pwdata[7:0];
				stdtm_pkg::ADDR_CMPA_LOW: s_next.cmpa[7:0] = pwdata[7:0];
				stdtm_pkg::ADDR_CMPA_HIGH: s_next.cmpa[15:8] = pwdata[7:0];
				stdtm_pkg::ADDR_PERIOD: s_next.cmpp = pwdata[7:0];
				stdtm_pkg::ADDR_FLAGS: begin
					clr_a = pwdata[stdtm_pkg::FLAG_A_BIT];
					clr_p = pwdata[stdtm_pkg::FLAG_P_BIT];
				end
				default: s_next.cmpp = s_reg.cmpp;
			endcase
		end

		// Sticky flags, set wins over clear
		s_next.flag_a = (s_reg.flag_a && !clr_a) || set_a;
		s_next.flag_p = (s_reg.flag_p && !clr_p) || set_p;
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign timer_output_pin = s_reg.pin;
	assign compare_a_flag = s_reg.flag_a;
	assign compare_p_flag = s_reg.flag_p;

endmodule

// file: hdl/stdtm_pkg.sv
// Shared constants and state type of the standard timer module
package stdtm_pkg;

	// ==========================================================
	// Register byte addresses
	localparam logic [7:0] ADDR_RUN_CLOCK = 8'h00;
	localparam logic [7:0] ADDR_MODE_OUT = 8'h04;
	localparam logic [7:0] ADDR_CNT_LOW = 8'h08;
	localparam logic [7:0] ADDR_CNT_HIGH = 8'h0c;
	localparam logic [7:0] ADDR_CMPA_LOW = 8'h10;
	localparam logic [7:0] ADDR_CMPA_HIGH = 8'h14;
	localparam logic [7:0] ADDR_PERIOD = 8'h18;
	localparam logic [7:0] ADDR_FLAGS = 8'h1c;

	// ==========================================================
	// Field positions in the run/clock control register
	localparam int RUN_BIT = 3;
	localparam int CLK_SEL_LSB = 4;
	localparam int PAUSE_BIT = 7;

	// Field positions in the mode/output control register
	localparam int CLR_SRC_BIT = 0;
	localparam int SWAP_BIT = 1;
	localparam int POL_BIT = 2;
	localparam int INIT_LVL_BIT = 3;
	localparam int PIN_FN_LSB = 4;
	localparam int MODE_LSB = 6;

	// Flag register bits
	localparam int FLAG_A_BIT = 0;
	localparam int FLAG_P_BIT = 1;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;

	// ==========================================================
	// Mode, pin function and clock select encodings
	localparam logic [1:0] MODE_COMPARE = 2'h0;
	localparam logic [1:0] MODE_UNDEF = 2'h1;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_TIMER = 2'h3;

	localparam logic [1:0] PFN_HOLD = 2'h0;
	localparam logic [1:0] PFN_LOW = 2'h1;
	localparam logic [1:0] PFN_HIGH = 2'h2;
	localparam logic [1:0] PFN_TOGGLE = 2'h3;
	localparam logic [1:0] PFN_INACTIVE = 2'h0;
	localparam logic [1:0] PFN_ACTIVE = 2'h1;
	localparam logic [1:0] PFN_PWM = 2'h2;
	localparam logic [1:0] PFN_PULSE = 2'h3;

	localparam logic [2:0] CKS_SYS_DIV4 = 3'h0;
	localparam logic [2:0] CKS_SYS = 3'h1;
	localparam logic [2:0] CKS_HI_DIV16 = 3'h2;
	localparam logic [2:0] CKS_HI_DIV64 = 3'h3;
	localparam logic [2:0] CKS_SUB_A = 3'h4;
	localparam logic [2:0] CKS_SUB_B = 3'h5;

	// Prescaler terminal counts
	localparam logic [1:0] SYS_DIV4_LAST = 2'h3;
	localparam logic [5:0] HI_DIV16_LAST = 6'h0f;
	localparam logic [5:0] HI_DIV64_LAST = 6'h3f;

	// ==========================================================
	// Whole state of the timer
	typedef struct packed {
		logic [7:0] run_ctrl;
		logic [7:0] mode_ctrl;
		logic [15:0] cmpa;
		logic [7:0] cmpp;
		logic [15:0] cnt;
		logic [1:0] sys_div;
		logic [5:0] hi_div;
		logic run_prev;
		logic lvl;
		logic flag_a;
		logic flag_p;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic pin;
	} stdtm_state_t;

endpackage

// file: bench/stdtm_monitor.sv
// Port checker for the standard timer module, with its bind
`timescale 1ns/1ps
module stdtm_monitor (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pin and flags
	input wire logic timer_output_pin,
	input wire logic compare_a_flag,
	input wire logic compare_p_flag
);
	// ==========================================================
	// Shadow of mode and run bits
	logic [7:0] mode_q;
	logic run_q;
	logic wr_done;
	logic [1:0] clr;
	assign wr_done = psel && penable && pready && pwrite;
	assign clr = (wr_done && paddr == stdtm_pkg::ADDR_FLAGS) ? pwdata[1:0] : 2'h0;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_q <= 8'h00;
			run_q <= 1'b0;
		end else if (wr_done && paddr == stdtm_pkg::ADDR_MODE_OUT) begin
			mode_q <= pwdata[7:0];
		end else if (wr_done && paddr == stdtm_pkg::ADDR_RUN_CLOCK) begin
			run_q <= pwdata[3];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// Assertions
	chk_ready_answer: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered in second cycle");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held too long");
	chk_err_mapped: assert property (pready && paddr < 8'h20 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("error on mapped address");
	chk_low_bits: assert property (pready && !pwrite && paddr == 8'h00 |-> prdata[2:0] == 3'h0)
		else $error("unimplemented bits not zero");
	chk_flag_a_hold: assert property ($fell(compare_a_flag) |-> $past(clr[0]) || $past(clr[0], 2) || $past(clr[0], 3))
		else $error("flag A fell without clear");
	chk_flag_p_hold: assert property ($fell(compare_p_flag) |-> $past(clr[1]) || $past(clr[1], 2) || $past(clr[1], 3))
		else $error("flag P fell without clear");
	chk_reset_quiet: assert property ($rose(rst_n) |-> !timer_output_pin && !compare_a_flag && !pready)
		else $error("outputs not quiet after reset");
	chk_pin_initial: assert property (wr_done && paddr == 8'h00 && pwdata[3] && !run_q && mode_q[7:6] == 2'h0
		|-> ##[1:3] timer_output_pin == (mode_q[3] ^ mode_q[2]))
		else $error("pin not at initial level after start");
	chk_timer_hold: assert property (mode_q[7:6] == 2'h3 |=> $stable(timer_output_pin))
		else $error("pin moved in timer mode");
	cover property (pslverr);
	cover property (mode_q[7:6] == 2'h2 && mode_q[1] && $fell(timer_output_pin));
	cover property ($rose(compare_a_flag));
	cover property ($rose(compare_p_flag));
endmodule
bind stdtm_top stdtm_monitor i_mon (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.timer_output_pin(timer_output_pin), .compare_a_flag(compare_a_flag), .compare_p_flag(compare_p_flag));

// file: bench/stdtm_ticks.sv
// Internal high-speed and sub clock strobe source
`timescale 1ns/1ps
module stdtm_ticks (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Strobes
	output logic high_clock_tick,
	output logic sub_clock_tick
);
	logic [2:0] cnt_reg;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_reg <= 3'h0;
		end else begin
			cnt_reg <= cnt_reg + 3'h1;
		end
	end
	// High clock at half rate, sub clock at one eighth
	assign high_clock_tick = cnt_reg[0];
	assign sub_clock_tick = cnt_reg == 3'h7;
endmodule

// file: bench/tb_top.sv
// Self-checking bench for the standard timer module
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, pin, fa, fp, hi_tick, sub_tick, err, ini, pol, pwm, exp_pin;
	logic [1:0] fn;
	int fails = 0;
	int checks_done = 0;
	int seed = 44489;
	int regs[8] = '{default: 0};
	int n, m, hi, a_val;
	always #2.5 clk = ~clk;
	stdtm_ticks i_ticks (.clk(clk), .rst_n(rst_n), .high_clock_tick(hi_tick), .sub_clock_tick(sub_tick));
	stdtm_top i_dut (.clk(clk), .rst_n(rst_n), .high_clock_tick(hi_tick), .sub_clock_tick(sub_tick),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timer_output_pin(pin), .compare_a_flag(fa), .compare_p_flag(fp));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ==========================================================
	// APB master and register model
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			fails++;
			complete_run();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
		if (a == 8'h00)
			regs[0] = d & 8'hf8;
		else if (a[4:2] inside {3'h1, 3'h4, 3'h5, 3'h6})
			regs[a[4:2]] = d;
	endtask
	task automatic rdchk(input logic [7:0] a);
		apb(1'b0, a, 8'h00);
		check(rd, 32'(regs[a[4:2]]));
	endtask
	task automatic rdcnt();
		apb(1'b0, 8'h08, 8'h00);
		n = rd[7:0];
		apb(1'b0, 8'h0c, 8'h00);
		n += int'(rd[7:0]) << 8;
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 7; i++)
			rdchk(8'(i * 4));
		wr(8'h00, 8'hf7);
		rdchk(8'h00);
		for (int i = 1; i < 7; i++) begin
			wr(8'(i * 4), 8'($random(seed)));
			rdchk(8'(i * 4));
		end
		apb(1'b0, 8'h20, 8'h00);
		check(err, 1'b1);
		check(rd, 32'h0);
		wr(8'h04, 8'h00);
		wr(8'h18, 8'h00);
		$display("Test registers done");
		for (int i = 0; i < 8; i++) begin
			wr(8'h00, 8'(i * 16 + 8));
			repeat (256) @(posedge clk);
			wr(8'h00, 8'(i * 16));
			rdcnt();
			case (i)
				0: hi = 64;
				1: hi = 256;
				2: hi = 8;
				3: hi = 2;
				6, 7: hi = 0;
				default: hi = 32;
			endcase
			check(n >= hi - 2 && n <= hi + (hi > 0 ? 6 : 0), 1'b1);
			m = n;
			rdcnt();
			check(n, m);
		end
		$display("Test clock select done");
		wr(8'h00, 8'h18);
		repeat (20) @(posedge clk);
		wr(8'h00, 8'h98);
		rdcnt();
		m = n;
		repeat (30) @(posedge clk);
		rdcnt();
		check(n, m);
		wr(8'h00, 8'h18);
		repeat (10) @(posedge clk);
		rdcnt();
		check(n > m + 5, 1'b1);
		wr(8'h00, 8'h00);
		$display("Test pause done");
		a_val = 4 + ($random(seed) & 31);
		wr(8'h10, 8'(a_val));
		wr(8'h14, 8'h00);
		for (int i = 0; i < 32; i++) begin
			{pwm, pol, ini, fn} = 5'(i);
			wr(8'h04, {pwm, 1'b0, fn, ini, pol, 2'b00});
			wr(8'h1c, 8'h03);
			wr(8'h00, 8'h18);
			repeat (4) @(posedge clk);
			check(pin, (pwm && fn == 2'h0 ? !ini : ini) ^ pol);
			check(fa, 1'b0);
			for (m = 0; m < 100 && fa !== 1'b1; m++)
				@(posedge clk);
			check(fa, 1'b1);
			check(fp, 1'b0);
			wr(8'h00, 8'h00);
			case ({pwm, fn})
				3'h0: exp_pin = ini;
				3'h1: exp_pin = 1'b0;
				3'h2: exp_pin = 1'b1;
				3'h5: exp_pin = ini;
				default: exp_pin = ~ini;
			endcase
			check(pin, exp_pin ^ pol);
		end
		$display("Test pin modes done");
		wr(8'h04, 8'hc1);
		wr(8'h1c, 8'h03);
		wr(8'h00, 8'h18);
		repeat (200) @(posedge clk);
		wr(8'h00, 8'h00);
		rdcnt();
		check(n < a_val, 1'b1);
		check(fa, 1'b1);
		check(fp, 1'b0);
		check(pin, 1'b1);
		wr(8'h04, 8'hc0);
		wr(8'h18, 8'h01);
		wr(8'h1c, 8'h03);
		wr(8'h00, 8'h18);
		repeat (300) @(posedge clk);
		wr(8'h00, 8'h00);
		rdcnt();
		check(n < 256, 1'b1);
		check(fp, 1'b1);
		$display("Test clear source done");
		wr(8'h10, 8'h00);
		wr(8'h14, 8'h02);
		wr(8'h04, 8'haa);
		wr(8'h1c, 8'h03);
		wr(8'h00, 8'h18);
		repeat (100) @(posedge clk);
		check(pin, 1'b1);
		repeat (300) @(posedge clk);
		check(pin, 1'b0);
		repeat (200) @(posedge clk);
		check(pin, 1'b1);
		check(fa, 1'b1);
		check(fp, 1'b1);
		wr(8'h00, 8'h00);
		$display("Test swapped PWM done");
		complete_run();
	end
endmodule
